// ==== src/liu_channel_status.sv ====
// Per-channel line interface status: change flags with clear-on-read, attenuation word,
// interrupt mask and output. Assumes line conditions are synchronous to clk.
module liu_channel_status (
    input wire logic clk, // 125 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire liu_status_pkg::line_cond_t line_cond, // Live receive conditions
    input wire logic [5:0] eq_setting, // Receive equalizer setting
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic irq, // Level interrupt, high
    output logic [12:0] loss_interval_bits // Active loss detection interval, 0 = internal
);
    import liu_status_pkg::*;

    // ==========================================
    // Address map decoding, shared by the write and read paths

    // Byte address of the addressed word; the low bits never pick a byte lane
    function automatic logic [7:0] word_addr(input logic [31:0] addr);
        return {addr[7:2], 2'b00};
    endfunction

    // Registers that answer a read with OKAY
    function automatic logic readable(input logic [7:0] addr);
        return addr == ADDR_CHANGE_FLAGS || addr == ADDR_ATTENUATION
            || addr == ADDR_IRQ_MASK || addr == ADDR_CONTROL
            || addr == ADDR_LIVE;
    endfunction

    // Registers that answer a write with OKAY; read-only ones drop the data
    function automatic logic writable(input logic [7:0] addr);
        return addr == ADDR_CHANGE_FLAGS || addr == ADDR_ATTENUATION
            || addr == ADDR_IRQ_MASK || addr == ADDR_CONTROL;
    endfunction

    // Byte lane 0 carries every implemented bit of a writable register
    function automatic logic lane0_write(input logic go, input logic [7:0] addr,
        input logic [7:0] target, input logic [3:0] strb);
        return go && addr == target && strb[0];
    endfunction

    // ==========================================
    // Reset release
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ==========================================
    // Write channel: take address and data in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [2:0] mask;
    line_ctrl_t ctrl;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_mask = lane0_write(wr_go, aw_addr, ADDR_IRQ_MASK, w_strb);
    wire wr_ctrl = lane0_write(wr_go, aw_addr, ADDR_CONTROL, w_strb);
    // Attenuation and flags are read-only; writes there are accepted and ignored
    wire wr_known = writable(aw_addr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= word_addr(s_axi_awaddr);
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !aw_take && !wr_go;
            s_axi_wready <= !w_held && !w_take && !wr_go;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= RESET_MASK;
            ctrl <= RESET_CONTROL;
        end else begin
            if (wr_mask) begin
                mask <= w_data[2:0];
            end
            if (wr_ctrl) begin
                ctrl <= w_data[2:0];
            end
        end
    end

    // ==========================================
    // Change detection and sticky flags
    line_cond_t cond_prev;
    logic [2:0] flags;
    logic [5:0] attenuation_word;
    wire active = ctrl.single_rail;
    wire [2:0] cond_now = {line_cond.alarm_ind_detected, line_cond.rx_signal_loss,
        line_cond.quasi_pattern_detected};
    wire [2:0] changed = active ? (cond_now ^ cond_prev) : 3'h0;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [7:0] rd_addr = word_addr(s_axi_araddr);
    wire rd_flags = rd_take && rd_addr == ADDR_CHANGE_FLAGS;
    wire alarm_ind_change_flag = flags[BIT_ALARM];
    wire rx_signal_loss_change_flag = flags[BIT_LOSS];
    wire quasi_pattern_change_flag = flags[BIT_QUASI];
    logic [2:0] next_flags;

    // Previous sample of the live conditions, the reference for change detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_prev <= 3'h0;
        end else begin
            cond_prev <= line_cond;
        end
    end

    // One sticky flag per condition; each is cleared by a read of the flags word
    generate
        for (genvar i = 0; i < 3; i++) begin : g_flag
            // Set wins over the clear of a same-cycle read, so no change is lost
            assign next_flags[i] = (flags[i] && !rd_flags) || changed[i];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flags[i] <= RESET_FLAGS[i];
                end else begin
                    flags[i] <= next_flags[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            attenuation_word <= RESET_ATTENUATION;
        end else begin
            attenuation_word <= eq_setting;
        end
    end

    // ==========================================
    // Read channel
    // Register words as seen by a read; unused upper bits are zero
    wire [31:0] flags_word = {29'h0000_0000, alarm_ind_change_flag,
        rx_signal_loss_change_flag, quasi_pattern_change_flag};
    wire [31:0] atten_word = {26'h000_0000, attenuation_word};
    wire [31:0] mask_word = {29'h0000_0000, mask};
    wire [31:0] ctrl_word = {29'h0000_0000, ctrl};
    wire [31:0] live_word = {29'h0000_0000, cond_prev};

    // Word selects of the read address
    wire sel_flags = rd_addr == ADDR_CHANGE_FLAGS;
    wire sel_atten = rd_addr == ADDR_ATTENUATION;
    wire sel_mask = rd_addr == ADDR_IRQ_MASK;
    wire sel_ctrl = rd_addr == ADDR_CONTROL;
    wire sel_live = rd_addr == ADDR_LIVE;

    // Unmapped addresses read as zero
    wire [31:0] rd_value = sel_flags ? flags_word :
        sel_atten ? atten_word :
        sel_mask ? mask_word :
        sel_ctrl ? ctrl_word :
        sel_live ? live_word : 32'h0000_0000;
    wire rd_known = readable(rd_addr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Interrupt and loss interval
    wire [12:0] ext_interval = 13'(LOSS_INTERVAL_EXT_BITS);
    // Pending events allowed through the mask, taken from the next flag state
    // so the interrupt follows the flags without an extra cycle of lag
    wire [2:0] pending = next_flags & mask;
    wire next_irq = active && |pending;
    wire [12:0] next_interval = ctrl.external_signal_loss_option ? ext_interval : 13'h0000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            loss_interval_bits <= 13'h0000;
        end else begin
            irq <= next_irq;
            loss_interval_bits <= next_interval;
        end
    end
endmodule

// ==== src/liu_status_pkg.sv ====
// Package for the per-channel line status block: offsets, field positions, resets, types.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package liu_status_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CHANGE_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_ATTENUATION = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_LIVE = 8'h10;
    // Field positions in the change flags register
    localparam int BIT_QUASI = 0;
    localparam int BIT_LOSS = 1;
    localparam int BIT_ALARM = 2;
    // Control register bits
    localparam int BIT_SINGLE_RAIL = 0;
    localparam int BIT_EXT_LOSS = 1;
    localparam int BIT_SYNC_MODE = 2;
    // Values after reset
    localparam logic [2:0] RESET_FLAGS = 3'h0;
    localparam logic [2:0] RESET_MASK = 3'h0;
    localparam logic [2:0] RESET_CONTROL = 3'h0;
    localparam logic [5:0] RESET_ATTENUATION = 6'h00;
    // Digital loss detection interval when the external option is on, in bits
    localparam int LOSS_INTERVAL_EXT_BITS = 4096;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic alarm_ind_detected;
        logic rx_signal_loss;
        logic quasi_pattern_detected;
    } line_cond_t;

    typedef struct packed {
        logic rx_sync_interface_mode;
        logic external_signal_loss_option;
        logic single_rail;
    } line_ctrl_t;
endpackage

// ==== sim/liu_status_chk.sv ====
// Checker for the line status block: flag and attenuation reads, loss interval.
// Bound into every liu_channel_status; sees its ports only.
module liu_status_chk (
    input wire logic clk, resetn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq, // Bus, irq
    input wire logic [31:0] s_axi_araddr, s_axi_rdata, // Read address and data
    input wire liu_status_pkg::line_cond_t line_cond, // Live conditions
    input wire logic [5:0] eq_setting, // Equalizer setting
    input wire logic [12:0] loss_interval_bits // Loss interval
);
    import liu_status_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Shadow of changes since the last flags read
    logic [7:0] ra;
    logic [2:0] lc_q, seen;
    wire ar_go = s_axi_arvalid && s_axi_arready;
    wire clr = ar_go && s_axi_araddr[7:0] == ADDR_CHANGE_FLAGS;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ra <= 8'h00;
            lc_q <= 3'h0;
            seen <= 3'h0;
        end else begin
            if (ar_go) ra <= s_axi_araddr[7:0];
            lc_q <= line_cond;
            seen <= (seen & ~{3{clr}}) | (line_cond ^ lc_q);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence rd_at(logic [7:0] a);
        $rose(s_axi_rvalid) && ra == a;
    endsequence
    chk_atten_value: assert property (rd_at(ADDR_ATTENUATION) |-> s_axi_rdata[5:0] == $past(eq_setting, 2))
        else $error("attenuation read differs from equalizer");
    chk_atten_bit_order: assert property (rd_at(ADDR_ATTENUATION) |->
        s_axi_rdata[5] == $past(eq_setting[5], 2) && s_axi_rdata[0] == $past(eq_setting[0], 2))
        else $error("attenuation bit order wrong");
    chk_atten_reserved: assert property (rd_at(ADDR_ATTENUATION) |-> s_axi_rdata[31:6] == 26'h000_0000)
        else $error("attenuation upper bits not zero");
    chk_alarm_flag: assert property (rd_at(ADDR_CHANGE_FLAGS) |-> !s_axi_rdata[2] || $past(seen[2]))
        else $error("alarm flag set without change");
    chk_loss_flag: assert property (rd_at(ADDR_CHANGE_FLAGS) |-> !s_axi_rdata[1] || $past(seen[1]))
        else $error("loss flag set without change");
    chk_quasi_flag: assert property (rd_at(ADDR_CHANGE_FLAGS) |-> !s_axi_rdata[0] || $past(seen[0]))
        else $error("pattern flag set without change");
    chk_flags_upper: assert property (rd_at(ADDR_CHANGE_FLAGS) |-> s_axi_rdata[31:3] == 29'h0000_0000)
        else $error("flags upper bits not zero");
    chk_interval_set: assert property (loss_interval_bits inside {13'h0000, 13'h1000})
        else $error("loss interval has an illegal value");
    cover property (rd_at(ADDR_CHANGE_FLAGS) ##0 s_axi_rdata[2:0] != 3'h0);
    cover property ($rose(irq));
    cover property (loss_interval_bits == 13'h1000);
endmodule

bind liu_channel_status liu_status_chk u_chk (.clk, .resetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .irq, .s_axi_araddr, .s_axi_rdata, .line_cond, .eq_setting, .loss_interval_bits);

// ==== sim/liu_channel_status_tb.sv ====
// Testbench for the line status block: AXI4-Lite master, line conditions, irq.
// Assumes the checker is bound to the design; clock 125 MHz.
module liu_channel_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import liu_status_pkg::*;
    // ==========
    logic clk = 1'b0, resetn = 1'b0, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arready;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [5:0] eq_setting = 6'h00;
    logic [12:0] loss_interval_bits;
    line_cond_t line_cond = '0;
    logic [31:0] exp_q[$];
    string name_q[$];
    logic [1:0] resp_q[$];
    int fails = 0, compares = 0, seed = 76988;
    always #4 clk = ~clk;
    liu_channel_status dut (.clk, .resetn, .line_cond, .eq_setting, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .loss_interval_bits);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit b = 0;
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid;
        end
        if (b) chk("bresp", {30'h0000_0000, s_axi_bresp}, 32'h0000_0000);
        if (!b) chk("write_timeout", 32'h0000_0000, 32'h0000_0001);
        if (!b) wrap_up();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bit r = 0;
        exp_q.push_back(e);
        name_q.push_back(nm);
        resp_q.push_back(a > ADDR_LIVE ? RESP_SLVERR : RESP_OKAY);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !r; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            r = s_axi_rvalid;
        end
        if (!r) chk("read_timeout", 32'h0000_0000, 32'h0000_0001);
        if (!r) wrap_up();
    endtask
    // Compares each read result with the oldest noted expectation
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
            chk(name_q.pop_front(), s_axi_rdata, exp_q.pop_front());
            chk("rresp", {30'h0000_0000, s_axi_rresp}, {30'h0000_0000, resp_q.pop_front()});
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ADDR_CHANGE_FLAGS, 32'h0000_0000, "flags_reset");
        for (int i = 0; i < 6; i++) begin
            eq_setting <= (i == 0) ? 6'h3F : 6'($random(seed));
            @(posedge clk);
            rd(ADDR_ATTENUATION, {26'h000_0000, eq_setting}, "atten");
        end
        wr(ADDR_ATTENUATION, 32'hFFFF_FFFF);
        wr(ADDR_CHANGE_FLAGS, 32'hFFFF_FFFF);
        rd(ADDR_ATTENUATION, {26'h000_0000, eq_setting}, "atten_ro");
        line_cond <= 3'h7;
        repeat (2) @(posedge clk);
        rd(ADDR_CHANGE_FLAGS, 32'h0000_0000, "flags_off");
        rd(ADDR_LIVE, 32'h0000_0007, "live");
        rd(8'h14, 32'h0000_0000, "unmapped");
        wr(ADDR_CONTROL, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk("interval", {19'h0_0000, loss_interval_bits}, 32'(LOSS_INTERVAL_EXT_BITS));
        wr(ADDR_IRQ_MASK, 32'h0000_0004);
        for (int i = 0; i < 3; i++) begin
            line_cond <= line_cond ^ (3'h1 << i);
            repeat (4) @(posedge clk);
            chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, i == 2});
            rd(ADDR_CHANGE_FLAGS, 32'h0000_0001 << i, "flag_set");
            rd(ADDR_CHANGE_FLAGS, 32'h0000_0000, "flag_clr");
            chk("irq_clr", {31'h0000_0000, irq}, 32'h0000_0000);
        end
        wr(ADDR_CONTROL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("interval_off", {19'h0_0000, loss_interval_bits}, 32'h0000_0000);
        wrap_up();
    end
endmodule
